// ===== sfr_pkg.sv
// constants, field layout and state codes of the smbus fault report slave
package sfr_pkg;

  // seven-bit bus addresses
  localparam logic [6:0] PTR_ADDR    = 7'h0C;
  localparam logic [6:0] CHA_ADDR_LO = 7'h50;
  localparam logic [6:0] CHA_ADDR_HI = 7'h52;
  localparam logic [6:0] CHB_ADDR_LO = 7'h51;
  localparam logic [6:0] CHB_ADDR_HI = 7'h53;

  // raw monitor inputs, index in the raw vector
  localparam int RAW_W     = 6;
  localparam int RAW_THERM = 0;
  localparam int RAW_UVLO  = 1;
  localparam int RAW_AMAIN = 2;
  localparam int RAW_APROG = 3;
  localparam int RAW_BMAIN = 4;
  localparam int RAW_BPROG = 5;

  // fault latches, they form status bits 7 down to 3
  localparam int FLT_W     = 5;
  localparam int LAT_SEV   = 4;
  localparam int LAT_AMAIN = 3;
  localparam int LAT_APROG = 2;
  localparam int LAT_BMAIN = 1;
  localparam int LAT_BPROG = 0;

  // constant status bits
  localparam logic       CHANNEL_COUNT_FLAG = 1'b0;
  localparam logic [1:0] RESERVED_BITS      = 2'h0;

  // command byte and frame fields
  localparam int         MASK_BIT = 0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_ZERO = 3'h0;
  localparam logic       RW_READ  = 1'b1;

  // reset values
  localparam logic [FLT_W-1:0] LATCH_RST = 5'h00;
  localparam logic [7:0]       BYTE_RST  = 8'h00;
  localparam logic             OE_OFF    = 1'b1;
  localparam logic             OE_ON     = 1'b0;

  typedef enum logic [2:0] {
    SFR_IDLE     = 3'b000,
    SFR_ADDR     = 3'b001,
    SFR_ADDR_ACK = 3'b010,
    SFR_RD_DATA  = 3'b011,
    SFR_RD_ACK   = 3'b100,
    SFR_WR_DATA  = 3'b101,
    SFR_WR_ACK   = 3'b110
  } sfr_state_t;

endpackage

// ===== sfr_fault_if.sv
// link between the bus slave and the fault capture logic
`timescale 1ns/100ps
interface sfr_fault_if;
  logic [sfr_pkg::FLT_W-1:0] faultLatch;
  logic                      alertPend;
  logic                      alertMask;
  logic                      ptrDone;
  logic                      statusDone;

  modport core (
    input  faultLatch,
    input  alertPend,
    output alertMask,
    output ptrDone,
    output statusDone
  );

  modport capture (
    output faultLatch,
    output alertPend,
    input  alertMask,
    input  ptrDone,
    input  statusDone
  );
endinterface

// ===== sfr_fault_capture.sv
// fault synchronisers, fault latches and alert pending flag
`timescale 1ns/100ps
module sfr_fault_capture (
  // clock, enable and reset
  input wire logic                      clk,
  input wire logic                      nrst,
  input wire logic                      ce,
  // analog monitor indications
  input wire logic [sfr_pkg::RAW_W-1:0] faultRaw,
  // slave side
  sfr_fault_if.capture                  fif
);

  logic [sfr_pkg::RAW_W-1:0] syncA;
  logic [sfr_pkg::RAW_W-1:0] syncB;
  logic [sfr_pkg::FLT_W-1:0] faultNow;
  logic [sfr_pkg::FLT_W-1:0] faultLatch;
  logic [sfr_pkg::FLT_W-1:0] next_faultLatch;
  logic                      alertPend;
  logic                      next_alertPend;

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers, stage A is read only by stage B
  genvar g;
  generate
    for (g = 0; g < sfr_pkg::RAW_W; g++) begin : gSync
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          syncA[g] <= 1'b0;
          syncB[g] <= 1'b0;
        end else if (ce) begin
          syncA[g] <= faultRaw[g];
          syncB[g] <= syncA[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // fault latches and alert
  always_comb begin
    faultNow = '0;
    faultNow[sfr_pkg::LAT_SEV]   = syncB[sfr_pkg::RAW_THERM] | syncB[sfr_pkg::RAW_UVLO];
    faultNow[sfr_pkg::LAT_AMAIN] = syncB[sfr_pkg::RAW_AMAIN];
    faultNow[sfr_pkg::LAT_APROG] = syncB[sfr_pkg::RAW_APROG];
    faultNow[sfr_pkg::LAT_BMAIN] = syncB[sfr_pkg::RAW_BMAIN];
    faultNow[sfr_pkg::LAT_BPROG] = syncB[sfr_pkg::RAW_BPROG];
    next_faultLatch = faultLatch;
    // a status read reloads from live faults, so a lasting fault latches again
    if (fif.statusDone) begin
      next_faultLatch = faultNow;
    end else if (faultLatch == sfr_pkg::LATCH_RST) begin
      // only the first set of faults is captured until a status read
      next_faultLatch = faultNow;
    end
    next_alertPend = alertPend;
    if (fif.ptrDone || fif.statusDone) begin
      next_alertPend = 1'b0;
    end
    // set beats clear, so a lasting fault raises the alert again
    if ((|faultNow) && !fif.alertMask) begin
      next_alertPend = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      faultLatch <= sfr_pkg::LATCH_RST;
      alertPend  <= 1'b0;
    end else if (ce) begin
      faultLatch <= next_faultLatch;
      alertPend  <= next_alertPend;
    end
  end

  assign fif.faultLatch = faultLatch;
  assign fif.alertPend  = alertPend;

endmodule

// ===== sfr_slave.sv
// smbus fault report slave: bus protocol, read bytes, alert pin
//
// Contract
// - interrupt-pointer read returns own seven-bit address in bits 7..1, reset zero.
// - status bit 7 latches thermal or undervoltage lockout faults.
// - status bits 6..3 latch socket A main, A prog, B main, B prog faults.
// - status bit 2 reads 0 for dual part; bits 1 and 0 read 0.
// - status byte is read at channel A address chosen by select pin.
// - on valid read address, acknowledge then shift data out with the clock.
// - write then repeated start is accepted as direction change to read.
// - never masters the bus; only pulls alert low by itself.
// - alert raised only for overcurrent, undervoltage lockout or thermal faults.
// - power-on reset clears all registers; contents kept while logic supply is up. Code resets sclQ, sdaQ and both output enables high, not zero.
// - alert asserts at once and stays latched; captured data survives fault removal.
// - interrupt-pointer read releases alert and sends own address.
// - lasting fault reasserts alert after pointer read; latches are not reloaded.
// - status read clears latches; lasting fault relatches bits and alert.
// - on contention lower address wins; loser stops, keeps alert low.
// - command bit 0 of channel A masks fault alerts of both channels.
// - on non-matching address stay off the bus until next start.
`timescale 1ns/100ps
module sfr_slave (
  // clock, enable and reset
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  // smbus pins, open drain, enable low drives low
  input  wire logic smbClk,
  input  wire logic smbDataIn,
  output logic      smbDataOut,
  output logic      smbDataOeN,
  // alert pin, open drain, enable low pulls low
  output logic      alertOut,
  output logic      alertOeN,
  // address select strap, high picks the upper address pair
  input  wire logic addrSel,
  // analog monitor fault indications, high is fault
  input  wire logic thermalFault,
  input  wire logic uvloFault,
  input  wire logic sockAMainFault,
  input  wire logic sockAProgFault,
  input  wire logic sockBMainFault,
  input  wire logic sockBProgFault,
  // alert mask as last committed by a channel A write
  output logic      alertMask
);

  function automatic logic [6:0] ownChA(input logic sel);
    ownChA = sel ? sfr_pkg::CHA_ADDR_HI : sfr_pkg::CHA_ADDR_LO;
  endfunction

  function automatic logic [6:0] ownChB(input logic sel);
    ownChB = sel ? sfr_pkg::CHB_ADDR_HI : sfr_pkg::CHB_ADDR_LO;
  endfunction

  sfr_fault_if fif ();

  sfr_pkg::sfr_state_t state;
  sfr_pkg::sfr_state_t next_state;
  logic [2:0] bitCnt;
  logic [2:0] next_bitCnt;
  logic [7:0] shiftReg;
  logic [7:0] next_shiftReg;
  logic [7:0] txByte;
  logic [7:0] next_txByte;
  logic       isPtr;
  logic       next_isPtr;
  logic       isRead;
  logic       next_isRead;
  logic       isChA;
  logic       next_isChA;
  logic       phase;
  logic       next_phase;
  logic       sclQ;
  logic       next_sclQ;
  logic       sdaQ;
  logic       next_sdaQ;
  logic       next_smbDataOeN;
  logic       next_alertOeN;
  logic       next_alertMask;
  logic       pendMask;
  logic       next_pendMask;
  logic       pendValid;
  logic       next_pendValid;
  logic       ptrDone;
  logic       next_ptrDone;
  logic       statusDone;
  logic       next_statusDone;

  logic       sclRise;
  logic       sclFall;
  logic       startSeen;
  logic       stopSeen;
  logic [7:0] addrByte;
  logic [7:0] retByte;
  logic [7:0] statusByte;

  ////////////////////////////////////////////////////////////////////////////
  // fault capture
  sfr_fault_capture uCapture (
    .clk      (clk),
    .nrst     (nrst),
    .ce       (ce),
    .faultRaw ({sockBProgFault, sockBMainFault, sockAProgFault,
                sockAMainFault, uvloFault, thermalFault}),
    .fif      (fif.capture)
  );

  assign fif.alertMask  = alertMask;
  assign fif.ptrDone    = ptrDone;
  assign fif.statusDone = statusDone;

  ////////////////////////////////////////////////////////////////////////////
  // bus conditions and read bytes
  assign sclRise  = smbClk & ~sclQ;
  assign sclFall  = ~smbClk & sclQ;
  // data falling while clock stays high is a start, hence the master's care
  assign startSeen = smbClk & sclQ & sdaQ & ~smbDataIn;
  assign stopSeen  = smbClk & sclQ & ~sdaQ & smbDataIn;
  assign addrByte  = {shiftReg[6:0], smbDataIn};
  assign retByte   = {ownChA(addrSel), 1'b0};
  assign statusByte = {fif.faultLatch, sfr_pkg::CHANNEL_COUNT_FLAG,
                       sfr_pkg::RESERVED_BITS};

  ////////////////////////////////////////////////////////////////////////////
  // protocol engine
  always_comb begin
    next_state      = state;
    next_bitCnt     = bitCnt;
    next_shiftReg   = shiftReg;
    next_txByte     = txByte;
    next_isPtr      = isPtr;
    next_isRead     = isRead;
    next_isChA      = isChA;
    next_phase      = phase;
    next_sclQ       = smbClk;
    next_sdaQ       = smbDataIn;
    next_smbDataOeN = smbDataOeN;
    next_alertMask  = alertMask;
    next_pendMask   = pendMask;
    next_pendValid  = pendValid;
    next_ptrDone    = 1'b0;
    next_statusDone = 1'b0;
    // the only self-started signalling is the alert pin
    next_alertOeN   = fif.alertPend ? sfr_pkg::OE_ON : sfr_pkg::OE_OFF;

    if (startSeen || stopSeen) begin
      // a completed channel A write byte takes effect on stop or repeated start
      if (pendValid) begin
        next_alertMask = pendMask;
        next_pendValid = 1'b0;
      end
      next_smbDataOeN = sfr_pkg::OE_OFF;
      next_bitCnt     = sfr_pkg::BIT_ZERO;
      next_state      = startSeen ? sfr_pkg::SFR_ADDR : sfr_pkg::SFR_IDLE;
    end else begin
      unique case (state)
        sfr_pkg::SFR_IDLE: begin
          // unmatched traffic is ignored here until the next start
          next_smbDataOeN = sfr_pkg::OE_OFF;
        end
        sfr_pkg::SFR_ADDR: begin
          if (sclRise) begin
            next_shiftReg = addrByte;
            next_bitCnt   = bitCnt + 3'h1;
            if (bitCnt == sfr_pkg::BIT_LAST) begin
              next_phase  = 1'b0;
              next_isRead = addrByte[0];
              next_isPtr  = 1'b0;
              next_isChA  = 1'b0;
              next_state  = sfr_pkg::SFR_ADDR_ACK;
              if (addrByte == {sfr_pkg::PTR_ADDR, sfr_pkg::RW_READ} && fif.alertPend) begin
                next_isPtr  = 1'b1;
                next_txByte = retByte;
              end else if (addrByte == {ownChA(addrSel), sfr_pkg::RW_READ}) begin
                next_txByte = statusByte;
              end else if (addrByte == {ownChA(addrSel), ~sfr_pkg::RW_READ}) begin
                next_isChA  = 1'b1;
              end else if (addrByte != {ownChB(addrSel), ~sfr_pkg::RW_READ}) begin
                next_state  = sfr_pkg::SFR_IDLE;
              end
            end
          end
        end
        sfr_pkg::SFR_ADDR_ACK: begin
          if (sclFall) begin
            if (!phase) begin
              next_smbDataOeN = sfr_pkg::OE_ON;
              next_phase      = 1'b1;
            end else if (isRead) begin
              // first data bit goes out while the clock is low
              next_smbDataOeN = txByte[7] ? sfr_pkg::OE_OFF : sfr_pkg::OE_ON;
              next_bitCnt     = sfr_pkg::BIT_ZERO;
              next_state      = sfr_pkg::SFR_RD_DATA;
            end else begin
              next_smbDataOeN = sfr_pkg::OE_OFF;
              next_bitCnt     = sfr_pkg::BIT_ZERO;
              next_state      = sfr_pkg::SFR_WR_DATA;
            end
          end
        end
        sfr_pkg::SFR_RD_DATA: begin
          if (sclRise) begin
            if (txByte[7] && !smbDataIn) begin
              // lost arbitration: drop off the bus, alert stays pending
              next_smbDataOeN = sfr_pkg::OE_OFF;
              next_state      = sfr_pkg::SFR_IDLE;
            end else if (bitCnt == sfr_pkg::BIT_LAST) begin
              next_ptrDone    = isPtr;
              next_statusDone = ~isPtr;
              next_phase      = 1'b0;
              next_state      = sfr_pkg::SFR_RD_ACK;
            end else begin
              next_bitCnt     = bitCnt + 3'h1;
            end
          end else if (sclFall) begin
            next_txByte     = {txByte[6:0], 1'b0};
            next_smbDataOeN = txByte[6] ? sfr_pkg::OE_OFF : sfr_pkg::OE_ON;
          end
        end
        sfr_pkg::SFR_RD_ACK: begin
          if (sclFall && !phase) begin
            next_smbDataOeN = sfr_pkg::OE_OFF;
            next_phase      = 1'b1;
          end else if (sclRise && phase) begin
            if (smbDataIn) begin
              next_state  = sfr_pkg::SFR_IDLE;
            end else begin
              // master asked for more: send the same kind of byte again
              next_txByte = isPtr ? retByte : statusByte;
              next_state  = sfr_pkg::SFR_ADDR_ACK;
            end
          end
        end
        sfr_pkg::SFR_WR_DATA: begin
          if (sclRise) begin
            next_shiftReg = addrByte;
            next_bitCnt   = bitCnt + 3'h1;
            if (bitCnt == sfr_pkg::BIT_LAST) begin
              if (isChA) begin
                next_pendMask  = addrByte[sfr_pkg::MASK_BIT];
                next_pendValid = 1'b1;
              end
              next_phase = 1'b0;
              next_state = sfr_pkg::SFR_WR_ACK;
            end
          end
        end
        sfr_pkg::SFR_WR_ACK: begin
          if (sclFall) begin
            if (!phase) begin
              next_smbDataOeN = sfr_pkg::OE_ON;
              next_phase      = 1'b1;
            end else begin
              // one command byte only; wait for stop or repeated start
              next_smbDataOeN = sfr_pkg::OE_OFF;
              next_state      = sfr_pkg::SFR_IDLE;
            end
          end
        end
        default: begin
          next_smbDataOeN = sfr_pkg::OE_OFF;
          next_state      = sfr_pkg::SFR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state      <= sfr_pkg::SFR_IDLE;
      bitCnt     <= sfr_pkg::BIT_ZERO;
      shiftReg   <= sfr_pkg::BYTE_RST;
      txByte     <= sfr_pkg::BYTE_RST;
      isPtr      <= 1'b0;
      isRead     <= 1'b0;
      isChA      <= 1'b0;
      phase      <= 1'b0;
      sclQ       <= 1'b1;
      sdaQ       <= 1'b1;
      smbDataOut <= 1'b0;
      smbDataOeN <= sfr_pkg::OE_OFF;
      alertOut   <= 1'b0;
      alertOeN   <= sfr_pkg::OE_OFF;
      alertMask  <= 1'b0;
      pendMask   <= 1'b0;
      pendValid  <= 1'b0;
      ptrDone    <= 1'b0;
      statusDone <= 1'b0;
    end else if (ce) begin
      state      <= next_state;
      bitCnt     <= next_bitCnt;
      shiftReg   <= next_shiftReg;
      txByte     <= next_txByte;
      isPtr      <= next_isPtr;
      isRead     <= next_isRead;
      isChA      <= next_isChA;
      phase      <= next_phase;
      sclQ       <= next_sclQ;
      sdaQ       <= next_sdaQ;
      smbDataOut <= 1'b0;
      smbDataOeN <= next_smbDataOeN;
      alertOut   <= 1'b0;
      alertOeN   <= next_alertOeN;
      alertMask  <= next_alertMask;
      pendMask   <= next_pendMask;
      pendValid  <= next_pendValid;
      ptrDone    <= next_ptrDone;
      statusDone <= next_statusDone;
    end
  end

endmodule

// ===== sfr_slave_chk.sv
// port checks of the smbus fault report slave
`timescale 1ns/100ps
module sfr_slave_chk (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // bus and alert pins
  input wire logic smbClk,
  input wire logic smbDataIn,
  input wire logic smbDataOut,
  input wire logic smbDataOeN,
  input wire logic alertOut,
  input wire logic alertOeN,
  input wire logic alertMask,
  // monitor indications
  input wire logic thermalFault,
  input wire logic uvloFault,
  input wire logic sockAMainFault,
  input wire logic sockAProgFault,
  input wire logic sockBMainFault,
  input wire logic sockBProgFault
);
  logic       anyFault;
  logic [3:0] sinceFault;
  logic [3:0] next_sinceFault;
  assign anyFault = thermalFault | uvloFault | sockAMainFault | sockAProgFault
                  | sockBMainFault | sockBProgFault;
  // cycles since any monitor last showed a fault
  always_comb begin
    next_sinceFault = sinceFault;
    if (anyFault) begin
      next_sinceFault = 4'h0;
    end else if (sinceFault != 4'hF) begin
      next_sinceFault = sinceFault + 4'h1;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sinceFault <= 4'hF;
    end else begin
      sinceFault <= next_sinceFault;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_reset_idle: assert property ($rose(nrst) |-> smbDataOeN && alertOeN && !alertMask)
    else $error("outputs not idle after reset");
  chk_never_master: assert property (!smbDataOut && !alertOut)
    else $error("pin value not low");
  chk_drive_clk_low: assert property ($fell(smbDataOeN) |-> !smbClk)
    else $error("data driven while clock high");
  chk_hold_clk_high: assert property (smbClk && $past(smbClk) |-> $stable(smbDataOeN))
    else $error("data changed while clock high");
  chk_alert_soon: assert property ($rose(anyFault) && !alertMask |-> ##[1:5] !alertOeN)
    else $error("alert late after fault");
  chk_alert_cause: assert property ($fell(alertOeN) |-> sinceFault <= 4'h6)
    else $error("alert without fault");
  chk_alert_release: assert property ($rose(alertOeN) |-> smbClk && $past(smbClk))
    else $error("alert released off a read");
  chk_mask_blocks: assert property (alertMask && $past(alertMask, 4) |-> !$fell(alertOeN))
    else $error("masked fault raised alert");
  chk_mask_commit: assert property ($changed(alertMask) |-> $past(smbClk) && $past(smbClk, 2))
    else $error("mask changed outside stop or start");
  chk_quiet_stop: assert property (smbClk && $past(smbClk) && $rose(smbDataIn)
                                   |=> smbDataOeN [*3])
    else $error("data driven after stop");
endmodule

bind sfr_slave sfr_slave_chk u_chk (
  .clk, .nrst, .smbClk, .smbDataIn, .smbDataOut, .smbDataOeN, .alertOut, .alertOeN,
  .alertMask, .thermalFault, .uvloFault, .sockAMainFault, .sockAProgFault,
  .sockBMainFault, .sockBProgFault
);

// ===== sfr_host_model.sv
// smbus host model: start, stop and bit transfers
`timescale 1ns/100ps
module sfr_host_model (
  // clock
  input  wire logic clk,
  // bus wires, pull-up resolved by the bench
  input  wire logic sda,
  output logic      scl,
  output logic      sdaLow
);
  int halfCyc = 4;
  initial begin
    scl    = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic tick();
    repeat (halfCyc) @(posedge clk);
  endtask
  // from a low clock this is a repeated start
  task automatic start();
    sdaLow <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sdaLow <= 1'b1;
    tick();
    scl <= 1'b0;
    tick();
  endtask
  task automatic stop();
    sdaLow <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sdaLow <= 1'b0;
    tick();
  endtask
  task automatic bitIo(input logic b, output logic r);
    sdaLow <= ~b;
    tick();
    scl <= 1'b1;
    tick();
    r = sda;
    scl <= 1'b0;
    tick();
  endtask
  // a released ack slot ends every read with no acknowledge
  task automatic byteIo(input logic [7:0] w, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bitIo(w[i], r[i]);
    end
    bitIo(1'b1, ack);
  endtask
endmodule

// ===== sfr_slave_test.sv
// self-checking bench of the smbus fault report slave
`timescale 1ns/100ps
module sfr_slave_test;
  typedef struct packed {logic sel; logic [5:0] raw; logic [7:0] status;} sfr_row_t;
  logic       clk;
  logic       nrst;
  logic       ce;
  logic       addrSel;
  logic [5:0] faults;
  logic       scl;
  logic       sdaLow;
  logic       sda;
  logic       smbDataOeN;
  logic       alertOeN;
  logic       alertMask;
  logic       alertLine;
  logic [7:0] junk;
  logic       ack;
  logic [6:0] own;
  int         mismatches = 0;
  int         numChecks = 0;
  int         cycles = 0;
  sfr_row_t   rows [7] = '{'{1'h0, 6'h01, 8'h80}, '{1'h0, 6'h02, 8'h80},
                           '{1'h0, 6'h04, 8'h40}, '{1'h0, 6'h08, 8'h20},
                           '{1'h0, 6'h10, 8'h10}, '{1'h0, 6'h20, 8'h08},
                           '{1'h1, 6'h14, 8'h50}};
  assign sda       = !(sdaLow || smbDataOeN === 1'b0);
  assign alertLine = (alertOeN === 1'b0) ? 1'b0 : 1'b1;
  sfr_slave u_dut (
    .clk, .nrst, .ce, .smbClk(scl), .smbDataIn(sda), .smbDataOut(), .smbDataOeN,
    .alertOut(), .alertOeN, .addrSel, .alertMask,
    .thermalFault(faults[sfr_pkg::RAW_THERM]), .uvloFault(faults[sfr_pkg::RAW_UVLO]),
    .sockAMainFault(faults[sfr_pkg::RAW_AMAIN]), .sockAProgFault(faults[sfr_pkg::RAW_APROG]),
    .sockBMainFault(faults[sfr_pkg::RAW_BMAIN]), .sockBProgFault(faults[sfr_pkg::RAW_BPROG])
  );
  sfr_host_model u_host (.clk, .sda, .scl, .sdaLow);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    numChecks++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic access(input logic [6:0] a, input logic rdBit, input logic [7:0] wd,
                        output logic ak, output logic [7:0] d);
    logic nk;
    u_host.start();
    u_host.byteIo({a, rdBit}, d, ak);
    if (ak === 1'b0) begin
      u_host.byteIo(rdBit ? 8'hFF : wd, d, nk);
    end
    u_host.stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic acked, input logic [7:0] want);
    logic       ak;
    logic [7:0] d;
    access(a, 1'b1, 8'h00, ak, d);
    check(ak, acked ? 8'h00 : 8'h01);
    if (acked) begin
      check(d, want);
    end
  endtask
  task automatic pulse(input logic [5:0] f);
    faults <= f;
    repeat (10) @(posedge clk);
    faults <= 6'h00;
    repeat (10) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      $display("[FAIL] %0t run too long", $time);
      give_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    nrst    = 1'b0;
    ce      = 1'b1;
    addrSel = 1'b0;
    faults  = 6'h00;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check(smbDataOeN, 8'h01);
    check(alertLine, 8'h01);
    check(alertMask, 8'h00);
    rd(sfr_pkg::PTR_ADDR, 1'b0, 8'h00);
    rd(7'h55, 1'b0, 8'h00);
    rd(sfr_pkg::CHB_ADDR_LO, 1'b0, 8'h00);
    $display("reset and refusals done");
    foreach (rows[i]) begin
      addrSel <= rows[i].sel;
      own = rows[i].sel ? sfr_pkg::CHA_ADDR_HI : sfr_pkg::CHA_ADDR_LO;
      pulse(rows[i].raw);
      check(alertLine, 8'h00);
      rd(sfr_pkg::PTR_ADDR, 1'b1, {own, 1'b0});
      check(alertLine, 8'h01);
      rd(own, 1'b1, rows[i].status);
      rd(own, 1'b1, 8'h00);
      $display("row %0d done", i);
    end
    addrSel <= 1'b0;
    faults  <= 6'h04;
    repeat (10) @(posedge clk);
    faults <= 6'h14;
    repeat (10) @(posedge clk);
    rd(sfr_pkg::PTR_ADDR, 1'b1, 8'hA0);
    repeat (8) @(posedge clk);
    check(alertLine, 8'h00);
    rd(sfr_pkg::CHA_ADDR_LO, 1'b1, 8'h40);
    rd(sfr_pkg::CHA_ADDR_LO, 1'b1, 8'h50);
    faults <= 6'h00;
    repeat (8) @(posedge clk);
    rd(sfr_pkg::CHA_ADDR_LO, 1'b1, 8'h50);
    check(alertLine, 8'h01);
    $display("lasting fault done");
    pulse(6'h01);
    u_host.start();
    u_host.byteIo({sfr_pkg::PTR_ADDR, 1'b1}, junk, ack);
    check(ack, 8'h00);
    u_host.byteIo(8'h00, junk, ack);
    u_host.stop();
    check(alertLine, 8'h00);
    rd(sfr_pkg::PTR_ADDR, 1'b1, 8'hA0);
    rd(sfr_pkg::CHA_ADDR_LO, 1'b1, 8'h80);
    $display("arbitration done");
    access(sfr_pkg::CHA_ADDR_LO, 1'b0, 8'h01, ack, junk);
    check(alertMask, 8'h01);
    pulse(6'h08);
    check(alertLine, 8'h01);
    access(sfr_pkg::CHA_ADDR_LO, 1'b1, 8'h00, ack, junk);
    u_host.halfCyc = 8;
    u_host.start();
    u_host.byteIo({sfr_pkg::CHA_ADDR_LO, 1'b0}, junk, ack);
    u_host.byteIo(8'h00, junk, ack);
    check(ack, 8'h00);
    u_host.start();
    u_host.byteIo({sfr_pkg::CHA_ADDR_LO, 1'b1}, junk, ack);
    check(ack, 8'h00);
    u_host.byteIo(8'hFF, junk, ack);
    u_host.stop();
    check(junk, 8'h00);
    check(alertMask, 8'h00);
    access(sfr_pkg::CHB_ADDR_LO, 1'b0, 8'h01, ack, junk);
    check(ack, 8'h00);
    check(alertMask, 8'h00);
    $display("mask and direction change done");
    pulse(6'h02);
    check(alertLine, 8'h00);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check(alertLine, 8'h01);
    check(smbDataOeN, 8'h01);
    rd(sfr_pkg::PTR_ADDR, 1'b0, 8'h00);
    rd(sfr_pkg::CHA_ADDR_LO, 1'b1, 8'h00);
    $display("mid-run reset done");
    give_verdict();
  end
endmodule
